//--- motion_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface motion_bus_if;
   logic                       cs_n;
   logic                       rd_n;
   logic                       wr_n;
   logic [motion_pkg::AW-1:0]  addr;
   logic [motion_pkg::DW-1:0]  h_data_o;
   logic                       h_data_oe;
   logic [motion_pkg::DW-1:0]  d_data_o;
   logic                       d_data_oe;
   logic [motion_pkg::DW-1:0]  data;
   logic                       d_irq_oe;
   logic                       irq_n;

   // Undriven bus floats high through pull-ups; the IRQ line is open drain.
   assign data  = d_data_oe ? d_data_o : (h_data_oe ? h_data_o : 12'hfff);
   assign irq_n = ~d_irq_oe;

   modport device (input cs_n, input rd_n, input wr_n, input addr, input data,
                   output d_data_o, output d_data_oe, output d_irq_oe);
   modport host (output cs_n, output rd_n, output wr_n, output addr, output h_data_o,
                 output h_data_oe, input data, input irq_n);
endinterface
`default_nettype wire

//--- motion_bus_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module motion_bus_monitor (
   input wire logic                      clk,
   input wire logic                      rstn,
   input wire logic                      cs_n,
   input wire logic                      rd_n,
   input wire logic                      wr_n,
   input wire logic [motion_pkg::AW-1:0] addr,
   input wire logic [motion_pkg::DW-1:0] h_data_o,
   input wire logic                      h_data_oe,
   input wire logic                      d_data_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_no_drive_fight: assert property (!(h_data_oe && d_data_oe))
      else $error("both ends drive data");
   a_strobe_excl: assert property (!(!rd_n && !wr_n))
      else $error("both strobes low");
   a_strobe_setup: assert property (($fell(rd_n) || $fell(wr_n)) |-> $past(!cs_n))
      else $error("strobe without prior select");
   a_wr_width: assert property ($fell(wr_n) |-> !wr_n [*4])
      else $error("write strobe too short");
   a_rd_width: assert property ($fell(rd_n) |-> !rd_n [*4])
      else $error("read strobe too short");
   a_wr_data_held: assert property ($rose(wr_n) |-> $past(h_data_oe) && $stable(h_data_o))
      else $error("write data moved at strobe rise");
   a_dev_drive_read: assert property ($rose(d_data_oe) |-> !cs_n && !rd_n)
      else $error("device drives outside read");
   a_dev_release: assert property ($rose(rd_n) |-> ##[1:8] !d_data_oe)
      else $error("device holds bus after read");
   a_select_hold: assert property ($rose(cs_n) |-> $past(rd_n && wr_n, 4))
      else $error("select released too early");
   a_ctrl_low_zero: assert property ($rose(wr_n) && addr == motion_pkg::A_CTRL |-> h_data_o[1:0] == 2'b00)
      else $error("reserved control bits written as one");
endmodule
`default_nettype wire

//--- motion_ctrl_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_status_regs (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   motion_bus_if.device                   bus,
   input  wire logic                      conv_done,
   input  wire logic                      rot_done,
   input  wire logic [motion_pkg::DW-1:0] conv_u,
   input  wire logic [motion_pkg::DW-1:0] conv_v,
   input  wire logic [motion_pkg::DW-1:0] conv_w,
   input  wire logic [motion_pkg::DW-1:0] conv_aux,
   input  wire logic [motion_pkg::DW-1:0] rot_res0,
   input  wire logic [motion_pkg::DW-1:0] rot_res1,
   input  wire logic [motion_pkg::DW-1:0] rot_res2,
   input  wire logic [motion_pkg::DW-1:0] rot_res3,
   output logic                           fwd_start,
   output logic                           rev_start,
   output logic [motion_pkg::DW-1:0]      fwd_angle,
   output logic [motion_pkg::DW-1:0]      rev_angle,
   output logic [motion_pkg::DW-1:0]      phase_in1,
   output logic [motion_pkg::DW-1:0]      phase_in2,
   output logic [motion_pkg::DW-1:0]      phase_in3,
   output logic                           conv_u_en,
   output logic                           conv_aux_en,
   output logic                           three_phase_mode,
   output logic                           rev_3of3,
   output logic                           sys_tick
);
   localparam int PW = 3 + motion_pkg::AW + motion_pkg::DW;

   // Pin vector: cs_n, rd_n, wr_n, addr, data.
   logic [PW-1:0]                s1_ff, s2_ff, s3_ff, stb_ff, prev_ff;
   logic [motion_pkg::DW-1:0]    ctrl_ff, status_ff;
   logic [motion_pkg::DW-1:0]    fwd_angle_ff, rev_angle_ff, ph1_ff, ph2_ff, ph3_ff;
   logic                         fwd_start_ff, rev_start_ff;
   logic [motion_pkg::DW-1:0]    data_o_ff, nxt_data;
   logic                         data_oe_ff, irq_oe_ff, div_ff, tick_ff;
   logic [2:0]                   edge_cnt_ff;
   logic                         cs_n_s, rd_n_s, wr_n_s, prev_rd_n, prev_wr_n;
   logic [motion_pkg::AW-1:0]    addr_s;
   logic [motion_pkg::DW-1:0]    data_s;
   logic                         wr_take, rd_end, conv_ev, rot_ev, any_ev, stat_clr;

   // A bit counts as changed only once the second and third stages agree.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_ff   <= '1;
         s2_ff   <= '1;
         s3_ff   <= '1;
         stb_ff  <= '1;
         prev_ff <= '1;
      end else begin
         s1_ff   <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.addr, bus.data};
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         stb_ff  <= (s2_ff & ~(s2_ff ^ s3_ff)) | (stb_ff & (s2_ff ^ s3_ff));
         prev_ff <= stb_ff;
      end
   end

   assign {cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = stb_ff;
   assign prev_rd_n = prev_ff[PW-2];
   assign prev_wr_n = prev_ff[PW-3];
   assign wr_take   = ~cs_n_s & wr_n_s & ~prev_wr_n; // see R21 see R22
   assign rd_end    = ~cs_n_s & rd_n_s & ~prev_rd_n;
   assign stat_clr  = rd_end & (addr_s == motion_pkg::A_STATUS); // see R19
   assign conv_ev   = conv_done & ctrl_ff[motion_pkg::CTL_CONV_IE]; // see R10
   assign rot_ev    = rot_done & ctrl_ff[motion_pkg::CTL_ROT_IE]; // see R09
   assign any_ev    = conv_ev | rot_ev;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= motion_pkg::CTRL_RESET; // see R14
      end else if (wr_take && addr_s == motion_pkg::A_CTRL) begin
         // Undefined and reserved bits are not stored and read back as zero.
         ctrl_ff <= data_s & motion_pkg::CTRL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fwd_angle_ff <= '0;
         rev_angle_ff <= '0;
         ph1_ff       <= '0;
         ph2_ff       <= '0;
         ph3_ff       <= '0;
         fwd_start_ff <= 1'b0;
         rev_start_ff <= 1'b0;
      end else begin
         fwd_start_ff <= wr_take && addr_s == motion_pkg::A_FWD_ANGLE; // see R02
         rev_start_ff <= wr_take && addr_s == motion_pkg::A_REV_ANGLE; // see R03
         if (wr_take) begin
            case (addr_s)
               motion_pkg::A_FWD_ANGLE: fwd_angle_ff <= data_s; // see R02 see R04
               motion_pkg::A_REV_ANGLE: rev_angle_ff <= data_s; // see R03 see R04
               motion_pkg::A_PHASE1:    ph1_ff <= data_s;
               motion_pkg::A_PHASE2:    ph2_ff <= data_s;
               motion_pkg::A_PHASE3:    ph3_ff <= data_s;
               default: begin
               end
            endcase
         end
      end
   end

   // An event in the cycle of the clearing read survives it.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_ff <= '0;
      end else begin
         if (conv_ev) begin
            status_ff[motion_pkg::ST_CONV] <= 1'b1; // see R15
         end else if (stat_clr) begin
            status_ff[motion_pkg::ST_CONV] <= 1'b0; // see R19
         end
         if (rot_ev) begin
            status_ff[motion_pkg::ST_ROT] <= 1'b1; // see R16
         end else if (stat_clr) begin
            status_ff[motion_pkg::ST_ROT] <= 1'b0; // see R19
         end
         if (any_ev) begin
            status_ff[motion_pkg::ST_IRQ] <= 1'b1; // see R18
         end else if (stat_clr) begin
            status_ff[motion_pkg::ST_IRQ] <= 1'b0; // see R19
         end
         // Valid drops when a new rotation starts and rises on its completion.
         if (rot_done) begin
            status_ff[motion_pkg::ST_VALID] <= 1'b1; // see R17
         end else if (fwd_start_ff || rev_start_ff) begin
            status_ff[motion_pkg::ST_VALID] <= 1'b0; // see R17
         end
      end
   end

   always_comb begin
      nxt_data = '0;
      case (addr_s)
         4'h0:                   nxt_data = rot_res0;
         4'h1:                   nxt_data = rot_res1;
         4'h2:                   nxt_data = rot_res2;
         4'h3:                   nxt_data = rot_res3;
         motion_pkg::A_CONV_U:   nxt_data = {conv_u[motion_pkg::DW-1:1], 1'b0}; // see R01
         motion_pkg::A_CONV_V:   nxt_data = {conv_v[motion_pkg::DW-1:1], 1'b0}; // see R01
         motion_pkg::A_CONV_W:   nxt_data = {conv_w[motion_pkg::DW-1:1], 1'b0}; // see R01
         motion_pkg::A_CONV_AUX: nxt_data = {conv_aux[motion_pkg::DW-1:1], 1'b0}; // see R01
         motion_pkg::A_CTRL:     nxt_data = ctrl_ff;
         motion_pkg::A_STATUS:   nxt_data = status_ff;
         default:                nxt_data = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_o_ff  <= '0;
         data_oe_ff <= 1'b0;
      end else begin
         data_o_ff  <= nxt_data;
         data_oe_ff <= ~cs_n_s & ~rd_n_s; // see R23
      end
   end

   // Edge mode gives a fixed low pulse per event, long enough for a host synchroniser.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         edge_cnt_ff <= '0;
         irq_oe_ff   <= 1'b0;
      end else if (ctrl_ff[motion_pkg::CTL_IRQ_LEVEL]) begin
         edge_cnt_ff <= '0;
         irq_oe_ff   <= status_ff[motion_pkg::ST_IRQ]; // see R11 see R24
      end else begin
         if (any_ev) begin
            edge_cnt_ff <= 3'(motion_pkg::IRQ_EDGE_CYCLES); // see R11 see R24
         end else if (edge_cnt_ff != '0) begin
            edge_cnt_ff <= edge_cnt_ff - 3'h1;
         end
         irq_oe_ff <= any_ev || edge_cnt_ff > 3'h1;
      end
   end

   // The slower rate is an enable on every other cycle, not a second clock.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_ff  <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= ~div_ff;
         tick_ff <= ~ctrl_ff[motion_pkg::CTL_DIV2] | div_ff; // see R07
      end
   end

   assign bus.d_data_o  = data_o_ff;
   assign bus.d_data_oe = data_oe_ff;
   assign bus.d_irq_oe  = irq_oe_ff;
   assign fwd_start     = fwd_start_ff;
   assign rev_start     = rev_start_ff;
   assign fwd_angle     = fwd_angle_ff;
   assign rev_angle     = rev_angle_ff;
   assign phase_in1     = ph1_ff;
   assign phase_in2     = ph2_ff;
   assign phase_in3     = ph3_ff;
   assign conv_u_en     = ctrl_ff[motion_pkg::CTL_U_EN]; // see R06
   assign conv_aux_en   = ctrl_ff[motion_pkg::CTL_AUX_EN]; // see R06
   assign three_phase_mode = ctrl_ff[motion_pkg::CTL_U_EN]; // see R06
   assign rev_3of3      = ctrl_ff[motion_pkg::CTL_REV_3OF3]; // see R12
   assign sys_tick      = tick_ff;
endmodule
`default_nettype wire

//--- motion_host.sv
`timescale 1ns/1ns
`default_nettype none
module motion_host #(
   parameter int EXT_CLK_HZ = motion_pkg::EXT_CLK_HZ_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   motion_bus_if.host       bus,
   input  wire logic [1:0]  cpu_addr,
   input  wire logic [15:0] cpu_wdata,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   output logic [15:0]      cpu_rdata
);
   localparam int PW = motion_pkg::DW + 1;

   motion_pkg::host_state_e   state_ff;
   logic [3:0]                cnt_ff;
   logic [motion_pkg::DW-1:0] wdata_ff, bus_wdata_ff, rdata_ff, ctrl_mirror_ff;
   logic [motion_pkg::AW-1:0] addr_ff;
   logic                      is_rd_ff, cs_n_ff, rd_n_ff, wr_n_ff, oe_ff, refused_ff;
   logic [PW-1:0]             s1_ff, s2_ff, s3_ff, stb_ff;
   logic [15:0]               cpu_rdata_ff;
   logic                      go, bad, cmd_rd;
   logic [motion_pkg::AW-1:0] cmd_addr;
   logic [motion_pkg::DW-1:0] ctrl_val;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_ff  <= '1;
         s2_ff  <= '1;
         s3_ff  <= '1;
         stb_ff <= '1;
      end else begin
         s1_ff  <= {bus.irq_n, bus.data};
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         stb_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (stb_ff & (s2_ff ^ s3_ff));
      end
   end

   assign cmd_rd   = cpu_wdata[motion_pkg::CMD_READ];
   assign cmd_addr = cpu_wdata[motion_pkg::AW-1:0];
   assign bad = cmd_rd ? motion_pkg::RD_RESERVED_MAP[cmd_addr] // see R20
                       : (motion_pkg::WR_RESERVED_MAP[cmd_addr] // see R20
                          || (cmd_addr == motion_pkg::A_FWD_ANGLE
                              && !ctrl_mirror_ff[motion_pkg::CTL_REV_3OF3])); // see R13
   assign go = cpu_wr && cpu_addr == motion_pkg::H_A_CMD && state_ff == motion_pkg::H_IDLE;

   // Reserved low bits forced clear; divide forced on when the clock is too fast.
   always_comb begin
      ctrl_val = wdata_ff & ~motion_pkg::CTRL_RESERVED_LOW; // see R05
      if (EXT_CLK_HZ > motion_pkg::DIV_LIMIT_HZ) begin
         ctrl_val[motion_pkg::CTL_DIV2] = 1'b1; // see R08
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wdata_ff <= '0;
      end else if (cpu_wr && cpu_addr == motion_pkg::H_A_DATA) begin
         wdata_ff <= cpu_wdata[motion_pkg::DW-1:0];
      end
   end

   // Commands given while busy are dropped silently; software polls the busy bit.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff       <= motion_pkg::H_IDLE;
         cnt_ff         <= '0;
         addr_ff        <= '0;
         is_rd_ff       <= 1'b0;
         bus_wdata_ff   <= '0;
         ctrl_mirror_ff <= motion_pkg::CTRL_RESET;
         rdata_ff       <= '0;
      end else begin
         case (state_ff)
            motion_pkg::H_IDLE: begin
               if (go && !bad) begin
                  addr_ff      <= cmd_addr;
                  is_rd_ff     <= cmd_rd;
                  bus_wdata_ff <= (cmd_addr == motion_pkg::A_CTRL) ? ctrl_val : wdata_ff;
                  if (!cmd_rd && cmd_addr == motion_pkg::A_CTRL) begin
                     ctrl_mirror_ff <= ctrl_val;
                  end
                  cnt_ff   <= 4'(motion_pkg::SETUP_CYCLES - 1);
                  state_ff <= motion_pkg::H_SETUP;
               end
            end
            motion_pkg::H_SETUP: begin
               if (cnt_ff == '0) begin
                  cnt_ff   <= 4'(motion_pkg::STROBE_CYCLES - 1);
                  state_ff <= motion_pkg::H_STROBE;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            motion_pkg::H_STROBE: begin
               if (cnt_ff == '0) begin
                  if (is_rd_ff) begin
                     rdata_ff <= stb_ff[motion_pkg::DW-1:0];
                  end
                  cnt_ff   <= 4'(motion_pkg::HOLD_CYCLES - 1);
                  state_ff <= motion_pkg::H_HOLD;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            motion_pkg::H_HOLD: begin
               if (cnt_ff == '0) begin
                  state_ff <= motion_pkg::H_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            default: state_ff <= motion_pkg::H_IDLE;
         endcase
      end
   end

   // Pins come from flops; data stays driven through the hold so the device sees it settled.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         oe_ff   <= 1'b0;
      end else begin
         cs_n_ff <= !(state_ff != motion_pkg::H_IDLE || (go && !bad)); // see R21
         rd_n_ff <= !(state_ff == motion_pkg::H_STROBE && is_rd_ff && cnt_ff != '0)
                    && !(state_ff == motion_pkg::H_SETUP && is_rd_ff && cnt_ff == '0);
         wr_n_ff <= !(state_ff == motion_pkg::H_STROBE && !is_rd_ff && cnt_ff != '0)
                    && !(state_ff == motion_pkg::H_SETUP && !is_rd_ff && cnt_ff == '0);
         oe_ff   <= (state_ff != motion_pkg::H_IDLE && !is_rd_ff)
                    && !(state_ff == motion_pkg::H_HOLD && cnt_ff == '0);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refused_ff <= 1'b0;
      end else if (go && bad) begin
         refused_ff <= 1'b1;
      end else if (cpu_rd && cpu_addr == motion_pkg::H_A_CMD) begin
         refused_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_rdata_ff <= '0;
      end else if (cpu_rd) begin
         cpu_rdata_ff <= '0;
         if (cpu_addr == motion_pkg::H_A_DATA) begin
            cpu_rdata_ff <= {4'h0, rdata_ff};
         end else if (cpu_addr == motion_pkg::H_A_CMD) begin
            cpu_rdata_ff[motion_pkg::HS_BUSY]    <= state_ff != motion_pkg::H_IDLE;
            cpu_rdata_ff[motion_pkg::HS_IRQ]     <= ~stb_ff[PW-1];
            cpu_rdata_ff[motion_pkg::HS_REFUSED] <= refused_ff;
         end
      end else begin
         cpu_rdata_ff <= '0;
      end
   end

   assign bus.cs_n      = cs_n_ff;
   assign bus.rd_n      = rd_n_ff;
   assign bus.wr_n      = wr_n_ff;
   assign bus.addr      = addr_ff;
   assign bus.h_data_o  = bus_wdata_ff;
   assign bus.h_data_oe = oe_ff;
   assign cpu_rdata     = cpu_rdata_ff;
endmodule
`default_nettype wire

//--- motion_pkg.sv
// Function
// R01: Conversion results twos complement, bit 0 zero.
// R02: Forward angle write stores and starts forward.
// R03: Reverse angle write stores and starts reverse.
// R04: Angles encode degrees over 360 times 4096.
// R05: Host writes zero to control bits 0, 1.
// R06: V, W always; bit 3 adds U, 4 aux.
// R07: Control bit 5 halves the system clock.
// R08: Host sets divide bit above 12.5 MHz clock.
// R09: Control bit 6 enables rotation-done interrupt.
// R10: Control bit 7 enables conversion-done interrupt.
// R11: Control bit 8 selects edge or level IRQ.
// R12: Control bit 10 selects reverse 3/3 mode.
// R13: Host sets bit 10 before forward transform.
// R14: All control bits reset to zero.
// R15: Status bit 0 flags enabled conversion done.
// R16: Status bit 1 flags enabled transform done.
// R17: Status bit 4 shows rotation results valid.
// R18: Status bit 11 flags any interrupt source.
// R19: Status read clears bits 0, 1, 11.
// R20: Host avoids reserved register locations.
// R21: Four address lines, chip select, two strobes.
// R22: Write register captures on write strobe rise.
// R23: Read register driven while select, strobe low.
// R24: Level IRQ holds; edge IRQ pulses per event.
`default_nettype none
package motion_pkg;
   localparam int DW = 12;
   localparam int AW = 4;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_PERIOD_NS = 20;

   localparam logic [AW-1:0] A_REV_ANGLE = 4'h0;
   localparam logic [AW-1:0] A_PHASE1 = 4'h1;
   localparam logic [AW-1:0] A_PHASE2 = 4'h2;
   localparam logic [AW-1:0] A_PHASE3 = 4'h3;
   localparam logic [AW-1:0] A_FWD_ANGLE = 4'h4;
   localparam logic [AW-1:0] A_CTRL = 4'hd;
   localparam logic [AW-1:0] A_CONV_V = 4'h5;
   localparam logic [AW-1:0] A_CONV_W = 4'h6;
   localparam logic [AW-1:0] A_CONV_AUX = 4'h7;
   localparam logic [AW-1:0] A_CONV_U = 4'h8;
   localparam logic [AW-1:0] A_STATUS = 4'he;
   localparam logic [15:0] WR_RESERVED_MAP = 16'hd800;
   localparam logic [15:0] RD_RESERVED_MAP = 16'h9e10;

   localparam int CTL_U_EN = 3;
   localparam int CTL_AUX_EN = 4;
   localparam int CTL_DIV2 = 5;
   localparam int CTL_ROT_IE = 6;
   localparam int CTL_CONV_IE = 7;
   localparam int CTL_IRQ_LEVEL = 8;
   localparam int CTL_REV_3OF3 = 10;
   localparam logic [DW-1:0] CTRL_RESET = 12'h000;
   localparam logic [DW-1:0] CTRL_MASK = 12'h5f8;
   localparam logic [DW-1:0] CTRL_RESERVED_LOW = 12'h003;

   localparam int ST_CONV = 0;
   localparam int ST_ROT = 1;
   localparam int ST_VALID = 4;
   localparam int ST_IRQ = 11;

   localparam int IRQ_EDGE_NS = 80;
   localparam int IRQ_EDGE_CYCLES = (IRQ_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_NS = 40;
   localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_NS = 240;
   localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_NS = 120;
   localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_LIMIT_HZ = 12_500_000;
   localparam int EXT_CLK_HZ_DEFAULT = 25_000_000;

   localparam logic [1:0] H_A_DATA = 2'h0;
   localparam logic [1:0] H_A_CMD = 2'h1;
   localparam int CMD_READ = 4;
   localparam int HS_BUSY = 0;
   localparam int HS_IRQ = 1;
   localparam int HS_REFUSED = 2;

   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_SETUP  = 2'b01,
      H_STROBE = 2'b10,
      H_HOLD   = 2'b11
   } host_state_e;

   // Whole degrees to an unsigned fraction of a turn; truncates toward zero.
   function automatic logic [DW-1:0] angle_from_degrees(input int deg);
      int scaled;
      scaled = (deg * 4096) / 360; // see R04
      return scaled[DW-1:0];
   endfunction
endpackage
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk, rstn, cpu_wr, cpu_rd, conv_done, rot_done, fwd_start, rev_start, sys_tick;
   logic        u_en, x_en, tp, r33;
   logic [1:0]  cpu_addr;
   logic [15:0] cpu_wdata, cpu_rdata, s, st;
   logic [11:0] cin [4], rres [4], ph [3], fwd_angle, rev_angle, v;
   logic [31:0] seed = 32'h7ef6;
   int          miscompares, checked, fcnt, rcnt, lo, f, n, k, i, mdl_ctrl, mdl_st;
   motion_bus_if bus ();
   motion_host #(.EXT_CLK_HZ(10_000_000)) i_motion_host (.clk(clk), .rstn(rstn), .bus(bus),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
   motion_ctrl_status_regs i_motion_ctrl_status_regs (.clk(clk), .rstn(rstn), .bus(bus),
      .conv_done(conv_done), .rot_done(rot_done), .conv_u(cin[0]), .conv_v(cin[1]), .conv_w(cin[2]),
      .conv_aux(cin[3]), .rot_res0(rres[0]), .rot_res1(rres[1]), .rot_res2(rres[2]), .rot_res3(rres[3]),
      .fwd_start(fwd_start), .rev_start(rev_start), .fwd_angle(fwd_angle), .rev_angle(rev_angle),
      .phase_in1(ph[0]), .phase_in2(ph[1]), .phase_in3(ph[2]), .conv_u_en(u_en), .conv_aux_en(x_en),
      .three_phase_mode(tp), .rev_3of3(r33), .sys_tick(sys_tick));
   motion_bus_monitor i_motion_bus_monitor (.clk(clk), .rstn(rstn), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
      .wr_n(bus.wr_n), .addr(bus.addr), .h_data_o(bus.h_data_o), .h_data_oe(bus.h_data_oe),
      .d_data_oe(bus.d_data_oe));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cw(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask
   task automatic cr(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge clk);
      cpu_rd <= 1'b0;
      #1 d = cpu_rdata;
   endtask
   // Polling the status clears the sticky refusal, so every poll is folded into the result.
   task automatic cmd(input logic [4:0] c, output logic [15:0] r);
      logic [15:0] p;
      cw(2'h1, {11'h0, c});
      r = 16'h0;
      for (int j = 0; j < 200; j++) begin
         cr(2'h1, p);
         r |= p;
         if (!p[0]) break;
      end
   endtask
   task automatic dw(input logic [3:0] a, input logic [11:0] d);
      cw(2'h0, {4'h0, d});
      cmd({1'b0, a}, st);
      // Model: only defined control bits stick; a start that runs drops the valid flag.
      if (a == motion_pkg::A_CTRL) mdl_ctrl = d & motion_pkg::CTRL_MASK;
      if (a == motion_pkg::A_REV_ANGLE || (a == motion_pkg::A_FWD_ANGLE && mdl_ctrl[10])) mdl_st &= ~16;
   endtask
   task automatic dr(input logic [3:0] a, output logic [15:0] d);
      cmd({1'b1, a}, st);
      cr(2'h0, d);
   endtask
   task automatic pulse(input logic rot);
      @(posedge clk);
      if (rot) rot_done <= 1'b1; else conv_done <= 1'b1;
      @(posedge clk);
      rot_done <= 1'b0;
      conv_done <= 1'b0;
      repeat (10) @(posedge clk);
      if (mdl_ctrl[rot ? motion_pkg::CTL_ROT_IE : motion_pkg::CTL_CONV_IE]) mdl_st |= (rot ? 2 : 1) | 12'h800;
      if (rot) mdl_st |= 16;
   endtask
   task automatic print_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      fcnt += fwd_start;
      rcnt += rev_start;
      lo += !bus.irq_n;
   end
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1_000_000;
      miscompares++;
      print_verdict();
   end
   initial begin
      {rstn, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, conv_done, rot_done} = '0;
      foreach (cin[j]) begin
         cin[j] = 12'(rnd()) | 12'h001;
         rres[j] = 12'(rnd());
      end
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      dr(motion_pkg::A_CTRL, s); chk(s, 0);
      dr(motion_pkg::A_STATUS, s); chk(s, 0);
      $display("reset test done");
      for (k = 0; k < 2; k++) begin
         v = (12'(rnd()) & 12'h5d8) | 12'h403 | 12'(k << 5);
         dw(motion_pkg::A_CTRL, v); dr(motion_pkg::A_CTRL, s); chk(s, mdl_ctrl);
         chk(u_en, v[3]); chk(x_en, v[4]); chk(tp, v[3]); chk(r33, v[10]);
         n = 0;
         repeat (10) begin @(posedge clk); #1 n += sys_tick; end
         chk(n, k ? 5 : 10);
      end
      $display("control test done");
      for (i = 0; i < 3; i++) begin v = 12'(rnd()); dw(4'(i + 1), v); chk(ph[i], v); end
      f = fcnt; dw(motion_pkg::A_FWD_ANGLE, 12'((45 * 4096) / 360)); chk(fwd_angle, 512); chk(fcnt, f + 1);
      f = rcnt; dw(motion_pkg::A_REV_ANGLE, 12'((90 * 4096) / 360)); chk(rev_angle, 1024); chk(rcnt, f + 1);
      dw(motion_pkg::A_CTRL, 0); f = fcnt; dw(motion_pkg::A_FWD_ANGLE, 12'h100);
      chk(st[2], 1); chk(fcnt, f);
      dw(4'hb, 12'h001); chk(st[2], 1);
      for (i = 0; i < 4; i++) begin dr(4'(i), s); chk(s, rres[i]); end
      dr(motion_pkg::A_CONV_U, s); chk(s, cin[0] & 12'hffe);
      dr(motion_pkg::A_CONV_V, s); chk(s, cin[1] & 12'hffe);
      dr(motion_pkg::A_CONV_W, s); chk(s, cin[2] & 12'hffe);
      dr(motion_pkg::A_CONV_AUX, s); chk(s, cin[3] & 12'hffe);
      $display("write and read test done");
      for (k = 0; k < 2; k++) begin
         dw(motion_pkg::A_CTRL, k ? 12'h4c0 : 12'h400);
         lo = 0; pulse(0); pulse(1);
         chk(lo, k * 8);
         dr(motion_pkg::A_STATUS, s); chk(s, mdl_st); mdl_st &= 16;
         dr(motion_pkg::A_STATUS, s); chk(s, 12'h010);
      end
      dw(motion_pkg::A_CTRL, 12'h580); pulse(0);
      repeat (20) @(posedge clk); chk(bus.irq_n, 0);
      dr(motion_pkg::A_STATUS, s); chk(s, mdl_st); chk(st[1], 1); mdl_st &= 16;
      repeat (10) @(posedge clk); chk(bus.irq_n, 1);
      dw(motion_pkg::A_REV_ANGLE, 12'h000); dr(motion_pkg::A_STATUS, s); chk(s, mdl_st);
      $display("event test done");
      print_verdict();
   end
endmodule
`default_nettype wire
